// >>> verilog/rbd_map.vh
`ifndef RBD_MAP_VH
`define RBD_MAP_VH
// ==========================================================
// Register offsets (word index on the plain port)
`define RBD_OFS_CTRL 8'h00
`define RBD_OFS_STAT 8'h01
`define RBD_OFS_PRLH 8'h02
`define RBD_OFS_PRLL 8'h03
`define RBD_OFS_CNTH 8'h04
`define RBD_OFS_CNTL 8'h05
`define RBD_OFS_ALRH 8'h06
`define RBD_OFS_ALRL 8'h07
`define RBD_OFS_PDIVH 8'h08
`define RBD_OFS_PDIVL 8'h09
`define RBD_OFS_BKP0 8'h10
// ==========================================================
// Control fields
`define RBD_CTRL_TICKIE 0
`define RBD_CTRL_ALRIE 1
`define RBD_CTRL_SEL_LO 2
`define RBD_CTRL_CALOE 4
`define RBD_CTRL_WAKEN 5
// Status fields
`define RBD_STAT_TICKF 0
`define RBD_STAT_ALRF 1
// Source selections
`define RBD_SRC_LSE 2'h0
`define RBD_SRC_LSI 2'h1
`define RBD_SRC_FEXT 2'h2
// ==========================================================
// Reset values and timing counts
`define RBD_PRL_RESET 20'h07FFF
`define RBD_CTRL_RESET 6'h00
`define RBD_FEXT_DIV 8'h80
`define RBD_CAL_DIV 8'h40
`endif

// >>> verilog/rbd_src_sel.v
`timescale 1ns/1ps
`default_nettype none
`include "rbd_map.vh"
// ==========================================================
// Source selector: picks one source-cycle strobe, fast clock divided by 128
module rbd_src_sel (
  input wire clk_i,
  input wire rstn_i,
  input wire [1:0] sel_i,
  input wire lse_tick_i,
  input wire lsi_tick_i,
  input wire fext_tick_i,
  output reg src_tick_o
);
  reg [6:0] div;
  wire div_wrap;
  assign div_wrap = (div == 7'h7F);
  // Divide fast external strobes by 128
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      div <= 7'h00;
    end else if (fext_tick_i) begin
      div <= div + 7'h01;
    end
  end
  // Registered selected strobe
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      src_tick_o <= 1'b0;
    end else begin
      case (sel_i)
        `RBD_SRC_LSE: src_tick_o <= lse_tick_i;
        `RBD_SRC_LSI: src_tick_o <= lsi_tick_i;
        `RBD_SRC_FEXT: src_tick_o <= fext_tick_i & div_wrap;
        default: src_tick_o <= 1'b0;
      endcase
    end
  end
endmodule // rbd_src_sel
`default_nettype wire

// >>> verilog/rbd_prescaler.v
`timescale 1ns/1ps
`default_nettype none
`include "rbd_map.vh"
// ==========================================================
// Prescaler: counts source strobes, ticks when reload reached
module rbd_prescaler #(
  parameter WIDTH = 20
) (
  input wire clk_i,
  input wire rstn_i,
  input wire src_tick_i,
  input wire [WIDTH-1:0] reload_i,
  input wire reload_wr_i,
  output reg [WIDTH-1:0] count_o,
  output reg tick_o
);
  // Count up, restart and tick at reload
  always @(posedge clk_i) begin
    if (!rstn_i || reload_wr_i) begin
      count_o <= {WIDTH{1'b0}};
      tick_o <= 1'b0;
    end else if (src_tick_i) begin
      if (count_o >= reload_i) begin
        count_o <= {WIDTH{1'b0}};
        tick_o <= 1'b1;
      end else begin
        count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
        tick_o <= 1'b0;
      end
    end else begin
      tick_o <= 1'b0;
    end
  end
endmodule // rbd_prescaler
`default_nettype wire

// >>> verilog/rbd_rtc.v
// Function
// - Ten 16-bit backup registers hold 20 bytes kept while the main supply is away.
// - Continuously running counters raise an alarm interrupt and a periodic interrupt.
// - The counting source is the 32.768 kHz oscillator, low-power RC, or fast clock / 128.
// - A 512 Hz reference output supports calibration of the crystal.
// - A 32-bit counter raises an alarm when it equals the compare register.
// - A 20-bit prescaler divides the source into the tick that advances the counter.
// - After reset the prescaler gives one tick per second from a 32.768 kHz source.
// - The clock keeps running in Stop and Standby modes.
// - The alarm drives an external event line so it can wake from Stop.
// - The alarm causes exit from Standby mode.
// - Backup domain registers keep their values across Standby.
`timescale 1ns/1ps
`default_nettype none
`include "rbd_map.vh"
module rbd_rtc #(
  parameter PRE_W = 20,
  parameter NBKP = 10
) (
  input wire clk_i,
  input wire rstn_i,
  input wire [7:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  input wire lse_tick_i,
  input wire lsi_tick_i,
  input wire fext_tick_i,
  output reg tick_irq_o,
  output reg alarm_irq_o,
  output reg alarm_event_o,
  output reg standby_wake_o,
  output reg cal_out_o
);
  // ==========================================================
  // Storage
  reg [5:0] ctrl;
  reg tick_flag;
  reg alarm_flag;
  reg [PRE_W-1:0] reload;
  reg [31:0] counter;
  reg [31:0] compare;
  reg [15:0] bkp [0:NBKP-1];
  reg [7:0] cal_div;
  wire src_tick;
  wire pre_tick;
  wire [PRE_W-1:0] pre_count;
  wire wr_prh;
  wire wr_prl;
  wire match;
  wire [1:0] src_sel;
  reg [15:0] next_rdata;
  integer k;

  assign src_sel = ctrl[`RBD_CTRL_SEL_LO+1:`RBD_CTRL_SEL_LO];
  assign wr_prh = wr_i && (addr_i == `RBD_OFS_PRLH);
  assign wr_prl = wr_i && (addr_i == `RBD_OFS_PRLL);
  assign match = pre_tick && ((counter + 32'h1) == compare);

  // ==========================================================
  // Source selection and prescaler
  rbd_src_sel u_sel (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .sel_i(src_sel),
    .lse_tick_i(lse_tick_i),
    .lsi_tick_i(lsi_tick_i),
    .fext_tick_i(fext_tick_i),
    .src_tick_o(src_tick)
  );
  rbd_prescaler #(.WIDTH(PRE_W)) u_pre (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .src_tick_i(src_tick),
    .reload_i(reload),
    .reload_wr_i(wr_prh | wr_prl),
    .count_o(pre_count),
    .tick_o(pre_tick)
  );

  // ==========================================================
  // Control, reload, compare
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl <= `RBD_CTRL_RESET;
      reload <= `RBD_PRL_RESET;
      compare <= 32'hFFFFFFFF;
    end else if (wr_i) begin
      case (addr_i)
        `RBD_OFS_CTRL: ctrl <= wdata_i[5:0];
        `RBD_OFS_PRLH: reload <= {wdata_i[PRE_W-17:0], reload[15:0]};
        `RBD_OFS_PRLL: reload <= {reload[PRE_W-1:16], wdata_i};
        `RBD_OFS_ALRH: compare <= {wdata_i, compare[15:0]};
        `RBD_OFS_ALRL: compare <= {compare[31:16], wdata_i};
        default: ctrl <= ctrl;
      endcase
    end
  end

  // Counter advances one per prescaler tick; writes load it
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      counter <= 32'h00000000;
    end else if (wr_i && addr_i == `RBD_OFS_CNTH) begin
      counter <= {wdata_i, counter[15:0]};
    end else if (wr_i && addr_i == `RBD_OFS_CNTL) begin
      counter <= {counter[31:16], wdata_i};
    end else if (pre_tick) begin
      counter <= counter + 32'h1;
    end
  end

  // Sticky flags: set wins over write-one-to-clear
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      tick_flag <= 1'b0;
      alarm_flag <= 1'b0;
    end else begin
      if (pre_tick) begin
        tick_flag <= 1'b1;
      end else if (wr_i && addr_i == `RBD_OFS_STAT && wdata_i[`RBD_STAT_TICKF]) begin
        tick_flag <= 1'b0;
      end
      if (match) begin
        alarm_flag <= 1'b1;
      end else if (wr_i && addr_i == `RBD_OFS_STAT && wdata_i[`RBD_STAT_ALRF]) begin
        alarm_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Backup registers: no functional reset, retained across Standby
  genvar g;
  generate
    for (g = 0; g < NBKP; g = g + 1) begin : g_bkp
      // Word index of this backup entry
      localparam [7:0] BKP_ADDR = `RBD_OFS_BKP0 + g;
      always @(posedge clk_i) begin
        if (wr_i && addr_i == BKP_ADDR) begin
          bkp[g] <= wdata_i;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Calibration output: source strobe divided by 64 gives 512 Hz
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      cal_div <= 8'h00;
      cal_out_o <= 1'b0;
    end else begin
      if (src_tick) begin
        cal_div <= (cal_div == `RBD_CAL_DIV - 8'h01) ? 8'h00 : cal_div + 8'h01;
      end
      cal_out_o <= ctrl[`RBD_CTRL_CALOE] & (cal_div < (`RBD_CAL_DIV >> 1));
    end
  end

  // ==========================================================
  // Interrupts, event line and standby wake, all registered
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      tick_irq_o <= 1'b0;
      alarm_irq_o <= 1'b0;
      alarm_event_o <= 1'b0;
      standby_wake_o <= 1'b0;
    end else begin
      tick_irq_o <= tick_flag & ctrl[`RBD_CTRL_TICKIE];
      alarm_irq_o <= alarm_flag & ctrl[`RBD_CTRL_ALRIE];
      alarm_event_o <= match;
      standby_wake_o <= match & ctrl[`RBD_CTRL_WAKEN];
    end
  end

  // ==========================================================
  // Read mux
  always @* begin
    next_rdata = 16'h0000;
    case (addr_i)
      `RBD_OFS_CTRL: next_rdata = {10'h000, ctrl};
      `RBD_OFS_STAT: next_rdata = {14'h0000, alarm_flag, tick_flag};
      `RBD_OFS_PRLH: next_rdata = {{(32-PRE_W){1'b0}}, reload[PRE_W-1:16]};
      `RBD_OFS_PRLL: next_rdata = reload[15:0];
      `RBD_OFS_CNTH: next_rdata = counter[31:16];
      `RBD_OFS_CNTL: next_rdata = counter[15:0];
      `RBD_OFS_ALRH: next_rdata = compare[31:16];
      `RBD_OFS_ALRL: next_rdata = compare[15:0];
      `RBD_OFS_PDIVH: next_rdata = {{(32-PRE_W){1'b0}}, pre_count[PRE_W-1:16]};
      `RBD_OFS_PDIVL: next_rdata = pre_count[15:0];
      default: begin
        for (k = 0; k < NBKP; k = k + 1) begin
          if (addr_i == (`RBD_OFS_BKP0 + k[7:0])) begin
            next_rdata = bkp[k];
          end
        end
      end
    endcase
  end

  // Read data registered, valid the cycle after the strobe only
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= rd_i ? next_rdata : 16'h0000;
    end
  end
endmodule // rbd_rtc
`default_nettype wire

// >>> verification/rbd_rtc_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker for the clock block
module rbd_chk (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic tick_irq_o,
  input wire logic alarm_irq_o,
  input wire logic alarm_event_o,
  input wire logic standby_wake_o,
  input wire logic cal_out_o
);
  logic [5:0] ctrl_sh;
  // Shadow of the control word
  always @(posedge clk_i) begin
    if (!rstn_i) ctrl_sh <= 6'h00;
    else if (wr_i && addr_i == 8'h00) ctrl_sh <= wdata_i[5:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data outside its slot");
  a_unmapped_read: assert property ($past(rd_i) && ($past(addr_i) > 8'h19 ||
    ($past(addr_i) > 8'h09 && $past(addr_i) < 8'h10)) |-> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($past(!rstn_i) |-> !tick_irq_o && !alarm_irq_o &&
    !alarm_event_o && !standby_wake_o && !cal_out_o) else $error("output high after reset");
  a_tick_masked: assert property (tick_irq_o |-> ctrl_sh[0] || $past(ctrl_sh[0]))
    else $error("tick irq while disabled");
  a_alarm_masked: assert property (alarm_irq_o |-> ctrl_sh[1] || $past(ctrl_sh[1]))
    else $error("alarm irq while disabled");
  a_event_pulse: assert property (alarm_event_o |=> !alarm_event_o)
    else $error("event longer than one cycle");
  a_wake_gate: assert property (standby_wake_o |-> alarm_event_o &&
    (ctrl_sh[5] || $past(ctrl_sh[5]))) else $error("wake without enabled match");
  a_cal_gate: assert property (cal_out_o |-> ctrl_sh[4] || $past(ctrl_sh[4]))
    else $error("reference output while off");
endmodule // rbd_chk
bind rbd_rtc rbd_chk rbd_chk_i (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tick_irq_o(tick_irq_o),
  .alarm_irq_o(alarm_irq_o), .alarm_event_o(alarm_event_o),
  .standby_wake_o(standby_wake_o), .cal_out_o(cal_out_o));
`default_nettype wire

// >>> verification/rbd_rtc_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench for the clock block
module rbd_rtc_bench;
  logic clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, ev = 1'b0, wk = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000, rd_v, base;
  logic [2:0] src_s = 3'h0;
  logic [15:0] rdata_o;
  logic tick_irq_o, alarm_irq_o, alarm_event_o, standby_wake_o, cal_out_o, cal_d = 1'b0;
  int miscompares = 0, n_compared = 0, tg = 0, s;
  rbd_rtc rbd_rtc_i (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .lse_tick_i(src_s[0]),
    .lsi_tick_i(src_s[1]), .fext_tick_i(src_s[2]), .tick_irq_o(tick_irq_o),
    .alarm_irq_o(alarm_irq_o), .alarm_event_o(alarm_event_o),
    .standby_wake_o(standby_wake_o), .cal_out_o(cal_out_o));
  // Clock at 20 MHz
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // Sticky capture of pulses and reference edges
  always @(posedge clk_i) begin
    if (alarm_event_o === 1'b1) ev <= 1'b1;
    if (standby_wake_o === 1'b1) wk <= 1'b1;
    cal_d <= cal_out_o;
    if (cal_d !== cal_out_o) tg <= tg + 1;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] exp);
    rd(a, rd_v);
    check(rd_v, exp);
  endtask
  // One-cycle strobes on one source, then let the pipeline settle
  task automatic pulse(input int b, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i) src_s[b] <= 1'b1;
      @(posedge clk_i) src_s[b] <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
    #1;
  endtask
  task automatic finish_test;
    if (miscompares == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #1ms miscompares++;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    rc(8'h00, 16'h0000);
    rc(8'h02, 16'h0000);
    rc(8'h03, 16'h7FFF);
    rc(8'h06, 16'hFFFF);
    rc(8'h07, 16'hFFFF);
    rc(8'h0A, 16'h0000);
    for (int i = 0; i < 10; i++) wr(8'h10 + i, 16'hA500 + i);
    wr(8'h1A, 16'h1234);
    @(posedge clk_i) rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 10; i++) rc(8'h10 + i, 16'hA500 + i);
    rc(8'h1A, 16'h0000);
    wr(8'h00, 16'h0001);
    wr(8'h02, 16'h0000);
    wr(8'h03, 16'h0003);
    pulse(0, 3);
    rc(8'h05, 16'h0000);
    rc(8'h09, 16'h0003);
    check(tick_irq_o, 1'b0);
    pulse(0, 1);
    rc(8'h05, 16'h0001);
    rc(8'h09, 16'h0000);
    rc(8'h01, 16'h0001);
    check(tick_irq_o, 1'b1);
    wr(8'h01, 16'h0001);
    repeat (3) @(posedge clk_i);
    check(tick_irq_o, 1'b0);
    wr(8'h06, 16'h0000);
    wr(8'h07, 16'h0003);
    wr(8'h00, 16'h0022);
    pulse(0, 4);
    check({alarm_irq_o, ev}, 2'h0);
    pulse(0, 4);
    rc(8'h05, 16'h0003);
    check({alarm_irq_o, ev, wk}, 3'h7);
    for (s = 0; s < 3; s++) begin
      wr(8'h00, 16'h0000 | (s << 2));
      wr(8'h03, 16'h0003);
      rd(8'h05, base);
      pulse(s == 0 ? 1 : 0, 4);
      pulse(s, (s == 2) ? 512 : 4);
      rc(8'h05, base + 16'h0001);
    end
    wr(8'h00, 16'h0010);
    pulse(0, 8);
    tg = 0;
    pulse(0, 128);
    check(16'(tg == 4 || tg == 3), 16'h0001);
    wr(8'h00, 16'h0000);
    pulse(0, 64);
    check(cal_out_o, 1'b0);
    wr(8'h04, 16'h00AB);
    rc(8'h04, 16'h00AB);
    finish_test;
  end
endmodule // rbd_rtc_bench
`default_nettype wire
